// >>> hdl/char_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`default_nettype none
module char_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} fifo_s;
	fifo_s st_ff, nxt_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign inReady = st_ff.cnt != (AW+1)'(DEPTH);
	assign outValid = st_ff.cnt != '0;
	assign outData = mem[st_ff.rd];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
		if (pop)
			nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
		if (push && !pop)
			nxt_st.cnt = st_ff.cnt + 1'b1;
		else if (pop && !push)
			nxt_st.cnt = st_ff.cnt - 1'b1;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	always_ff @(posedge mclk) begin
		if (push)
			mem[st_ff.wr] <= inData;
	end
endmodule // char_fifo
`default_nettype wire

// >>> hdl/print_head_ctrl.sv
// Print head, drive motor and line feed control for a 5x7 matrix printer
`default_nettype none
module print_head_ctrl #(
	parameter int unsigned PULSE_CYC = print_head_pkg::PULSE_CYC,
	parameter int unsigned PAUSE_CYC = print_head_pkg::PAUSE_CYC,
	parameter int unsigned LF_CYC    = print_head_pkg::LF_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [7:0] hostWrData,
	input  wire logic       hostWrStb,
	output logic      [7:0] hostRdData,
	input  wire logic       hostRdStb,
	output logic      [3:0] hostStatus,
	input  wire logic [7:0] hostMsgData,
	input  wire logic       hostMsgStb,
	input  wire logic [6:0] colPattern,
	output logic      [7:0] glyphChar,
	output logic      [2:0] glyphCol,
	output logic      [6:0] solenoidOn,
	output logic            mainMotorOn,
	output logic            feedMotorOn,
	input  wire logic       homeSwitch,
	input  wire logic       paper_advance_switch
);
	// Character ROM lives outside; colPattern answers glyphChar/glyphCol
	// combinationally on the same clock.
	typedef struct packed {
		print_head_pkg::phase_e phase;
		logic [31:0] timer;
		logic [5:0]  charIdx;
		logic [2:0]  col;
		logic [7:0]  curChar;
		logic        haveChar;
		logic        lineDone;
		logic [7:0]  dataReg;
		logic        inFull;
		logic [7:0]  rdReg;
		logic        outFull;
		logic [1:0]  homeSync;
		logic [1:0]  feedSync;
		logic        homeQ;
		logic        feedQ;
		logic [6:0]  sol;
		logic        mainOn;
		logic        feedOn;
		logic [7:0]  glyph;
		logic [2:0]  gcol;
	} state_s;
	state_s st_ff, nxt_st;

	logic [7:0] fifoData;
	logic       fifoValid;
	logic       fifoReady;
	logic       fifoInReady;
	logic       homeFall;
	logic       feedFall;

	char_fifo #(
		.WIDTH(print_head_pkg::DATA_W),
		.DEPTH(print_head_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk    (mclk),
		.rstn    (rstn),
		.inData  (st_ff.dataReg),
		.inValid (st_ff.inFull),
		.inReady (fifoInReady),
		.outData (fifoData),
		.outValid(fifoValid),
		.outReady(fifoReady)
	);

	assign homeFall = st_ff.homeQ && !st_ff.homeSync[1];
	assign feedFall = st_ff.feedQ && !st_ff.feedSync[1];
	assign fifoReady = !st_ff.haveChar && !st_ff.lineDone;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.homeSync = {st_ff.homeSync[0], homeSwitch};
		nxt_st.feedSync = {st_ff.feedSync[0], paper_advance_switch};
		nxt_st.homeQ = st_ff.homeSync[1];
		nxt_st.feedQ = st_ff.feedSync[1];
		// Byte-wide data register; held until the FIFO takes it
		if (st_ff.inFull && fifoInReady)
			nxt_st.inFull = 1'b0;
		if (hostWrStb && !st_ff.inFull) begin
			nxt_st.dataReg = hostWrData;
			nxt_st.inFull = 1'b1;
		end
		if (hostRdStb)
			nxt_st.outFull = 1'b0;
		if (hostMsgStb) begin
			nxt_st.rdReg = hostMsgData;
			nxt_st.outFull = 1'b1;
		end
		// Pull the next character; line end or 40 chars close the line
		if (fifoValid && fifoReady) begin
			if (fifoData == print_head_pkg::LINE_END)
				nxt_st.lineDone = 1'b1;
			else begin
				nxt_st.curChar = fifoData;
				nxt_st.haveChar = 1'b1;
			end
		end
		if (st_ff.timer != '0)
			nxt_st.timer = st_ff.timer - 1'b1;
		case (st_ff.phase)
			print_head_pkg::IDLE: begin
				nxt_st.sol = '0;
				if (st_ff.haveChar || st_ff.lineDone) begin
					nxt_st.mainOn = 1'b1;
					nxt_st.phase = print_head_pkg::WAIT_HOME;
				end
			end
			print_head_pkg::WAIT_HOME: begin
				if (homeFall) begin
					nxt_st.charIdx = '0;
					nxt_st.col = '0;
					nxt_st.phase = print_head_pkg::PAUSE;
					nxt_st.timer = '0;
				end
			end
			print_head_pkg::PAUSE: begin
				nxt_st.sol = '0;
				if (st_ff.timer == '0) begin
					if (!st_ff.haveChar && st_ff.lineDone ||
					    st_ff.charIdx == 6'(print_head_pkg::LINE_CHARS)) begin
						nxt_st.feedOn = 1'b1;
						nxt_st.timer = LF_CYC;
						nxt_st.phase = print_head_pkg::FEED;
					end else if (st_ff.haveChar &&
					    st_ff.glyph == st_ff.curChar &&
					    st_ff.gcol == st_ff.col) begin
						// ROM address lags a fresh char by one cycle
						nxt_st.sol = colPattern;
						nxt_st.timer = PULSE_CYC - 1;
						nxt_st.phase = print_head_pkg::PULSE;
					end
				end
			end
			print_head_pkg::PULSE: begin
				if (st_ff.timer == '0) begin
					nxt_st.sol = '0;
					nxt_st.timer = PAUSE_CYC - 1;
					nxt_st.phase = print_head_pkg::PAUSE;
					if (st_ff.col == 3'(print_head_pkg::COLS - 1)) begin
						nxt_st.col = '0;
						nxt_st.charIdx = st_ff.charIdx + 1'b1;
						nxt_st.haveChar = 1'b0;
					end else
						nxt_st.col = st_ff.col + 1'b1;
				end
			end
			print_head_pkg::FEED: begin
				nxt_st.sol = '0;
				if (feedFall || st_ff.timer == '0) begin
					nxt_st.feedOn = 1'b0;
					nxt_st.lineDone = 1'b0;
					nxt_st.phase = print_head_pkg::WAIT_LINE;
				end
			end
			print_head_pkg::WAIT_LINE: begin
				nxt_st.mainOn = st_ff.haveChar || fifoValid || st_ff.inFull;
				nxt_st.phase = print_head_pkg::IDLE;
			end
			default: begin
				nxt_st.sol = '0;
				nxt_st.phase = print_head_pkg::IDLE;
			end
		endcase
		// Address registered one cycle behind curChar/col; fire waits until they match
		nxt_st.glyph = st_ff.curChar;
		nxt_st.gcol = st_ff.col;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign solenoidOn = st_ff.sol;
	assign mainMotorOn = st_ff.mainOn;
	assign feedMotorOn = st_ff.feedOn;
	assign glyphChar = st_ff.glyph;
	assign glyphCol = st_ff.gcol;
	assign hostRdData = st_ff.rdReg;
	always_comb begin
		hostStatus = '0;
		hostStatus[print_head_pkg::ST_OUT_FULL] = st_ff.outFull;
		hostStatus[print_head_pkg::ST_IN_FULL] = st_ff.inFull;
		hostStatus[print_head_pkg::ST_PRINTING] = st_ff.mainOn;
		hostStatus[print_head_pkg::ST_FEEDING] = st_ff.feedOn;
	end
endmodule // print_head_ctrl
`default_nettype wire

// >>> hdl/print_head_pkg.sv
// Constants shared by the print head controller
// What this block does
// - Seven separate solenoid outputs each fire the wire for one dot row.
// - A character is five column patterns fired at five instants.
// - Dots fire only during the left to right sweep, never on return.
// - A new line starts on the falling edge of the home switch.
// - Feed motor stops on the falling edge of the paper advance switch.
// - A line holds at most 40 characters.
// - The link is seven solenoid drives, two motor drives, two switches.
// - The master sees one byte data register and a 4-bit status register.
// - Each dot is a pulse of about 400 us, then a pause of about 900 us.
// - Solenoids fire at most once per 1.3 ms, timed internally.
// - After the last dot feed runs through the switch cycle, about 200 ms.
`default_nettype none
package print_head_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned PULSE_US = 400;
	localparam int unsigned PAUSE_US = 900;
	localparam int unsigned LF_MS = 200;
	localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
	localparam int unsigned PAUSE_CYC = PAUSE_US * CLK_MHZ;
	localparam int unsigned LF_CYC = LF_MS * 1000 * CLK_MHZ;
	localparam int unsigned ROWS = 7;
	localparam int unsigned COLS = 5;
	localparam int unsigned LINE_CHARS = 40;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DATA_W = 8;
	// Status bit positions
	localparam int unsigned ST_OUT_FULL = 0;
	localparam int unsigned ST_IN_FULL = 1;
	localparam int unsigned ST_PRINTING = 2;
	localparam int unsigned ST_FEEDING = 3;
	localparam logic [7:0] LINE_END = 8'h0d;
	typedef enum logic [2:0] {
		IDLE, WAIT_HOME, PULSE, PAUSE, FEED, WAIT_LINE
	} phase_e;
endpackage
`default_nettype wire

// >>> sim/print_head_properties.sv
// Port checker for the print head controller
`default_nettype none
module print_head_properties #(
	parameter int unsigned PULSE_CYC = 4,
	parameter int unsigned PAUSE_CYC = 9,
	parameter int unsigned LF_CYC    = 200
) (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic [7:0] hostRdData,
	input wire logic [7:0] hostMsgData,
	input wire logic       hostMsgStb,
	input wire logic [6:0] solenoidOn,
	input wire logic       mainMotorOn,
	input wire logic       feedMotorOn,
	input wire logic       homeSwitch,
	input wire logic       paper_advance_switch
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	logic [31:0] onCnt;
	logic [31:0] offCnt;
	logic [31:0] fdCnt;
	wire logic   firing = |solenoidOn;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			onCnt <= '0;
			offCnt <= 32'h0000ffff;
			fdCnt <= '0;
		end else begin
			onCnt <= firing ? onCnt + 32'h1 : '0;
			offCnt <= firing ? '0 : offCnt + 32'h1;
			fdCnt <= feedMotorOn ? fdCnt + 32'h1 : '0;
		end
	end
	sequence homeDrop;
		$fell(homeSwitch) && mainMotorOn && !feedMotorOn && !firing;
	endsequence
	sequence feedDone;
		feedMotorOn && $fell(paper_advance_switch);
	endsequence
	chk_reset_idle: assert property (
		$rose(rstn) |-> !firing && !mainMotorOn && !feedMotorOn)
		else $error("output active after reset");
	chk_pulse_len: assert property (
		$fell(firing) |-> onCnt == PULSE_CYC)
		else $error("dot pulse length wrong");
	chk_pause_gap: assert property (
		$rose(firing) |-> offCnt >= PAUSE_CYC)
		else $error("dot pause too short");
	chk_fire_sweep: assert property (
		firing |-> mainMotorOn && !feedMotorOn)
		else $error("dots fired outside sweep");
	chk_line_start: assert property (
		homeDrop |-> ##[2:8] firing)
		else $error("line did not start");
	chk_feed_stop: assert property (
		feedDone |-> ##[1:5] !feedMotorOn)
		else $error("feed motor not stopped");
	chk_feed_bound: assert property (
		feedMotorOn |-> fdCnt < LF_CYC + 4)
		else $error("feed motor on too long");
	chk_msg_load: assert property (
		hostMsgStb |=> hostRdData == $past(hostMsgData))
		else $error("message byte not loaded");
endmodule // print_head_properties
bind print_head_ctrl print_head_properties #(.PULSE_CYC(PULSE_CYC),
	.PAUSE_CYC(PAUSE_CYC), .LF_CYC(LF_CYC)) u_chk (.mclk(mclk),
	.rstn(rstn), .hostRdData(hostRdData), .hostMsgData(hostMsgData),
	.hostMsgStb(hostMsgStb), .solenoidOn(solenoidOn),
	.mainMotorOn(mainMotorOn), .feedMotorOn(feedMotorOn),
	.homeSwitch(homeSwitch), .paper_advance_switch(paper_advance_switch));
`default_nettype wire

// >>> sim/printer_model.sv
// Printer mechanics: drum, feed contact and dot table
`default_nettype none
module printer_model (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       mainMotorOn,
	input  wire logic       feedMotorOn,
	input  wire logic [7:0] glyphChar,
	input  wire logic [2:0] glyphCol,
	output logic            homeSwitch,
	output logic            paper_advance_switch,
	output logic      [6:0] colPattern
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] drumPos;
	logic [5:0]  feedPos;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			drumPos <= 12'h000;
			feedPos <= 6'h00;
		end else begin
			drumPos <= drumPos + {11'h000, mainMotorOn};
			feedPos <= feedMotorOn ? feedPos + 6'h01 : 6'h00;
		end
	end
	// Head parked at home until the drum turns
	assign homeSwitch = drumPos < 12'h028;
	assign paper_advance_switch = feedPos > 6'h09 && feedPos < 6'h1e;
	// Dots depend on char and column so a wrong lookup shows
	assign colPattern = {glyphChar[1:0], 5'h01 << glyphCol};
endmodule // printer_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the print head controller
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
	n_errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] hostWrData = 8'h00;
	logic       hostWrStb = 1'b0;
	logic       hostRdStb = 1'b0;
	logic [7:0] hostMsgData = 8'h00;
	logic       hostMsgStb = 1'b0;
	logic [7:0] hostRdData;
	logic [3:0] hostStatus;
	logic [6:0] colPattern;
	logic [7:0] glyphChar;
	logic [2:0] glyphCol;
	logic [6:0] solenoidOn;
	logic       mainMotorOn;
	logic       feedMotorOn;
	logic       homeSwitch;
	logic       paperSw;
	logic       prevOn = 1'b0;
	logic [6:0] q[$];
	int         n_errors = 0;
	int         num_checks = 0;
	int         cyc = 0;
	print_head_ctrl #(.PULSE_CYC(4), .PAUSE_CYC(9), .LF_CYC(200)) u_dut (
		.mclk(mclk), .rstn(rstn), .hostWrData(hostWrData),
		.hostWrStb(hostWrStb), .hostRdData(hostRdData),
		.hostRdStb(hostRdStb), .hostStatus(hostStatus),
		.hostMsgData(hostMsgData), .hostMsgStb(hostMsgStb),
		.colPattern(colPattern), .glyphChar(glyphChar),
		.glyphCol(glyphCol), .solenoidOn(solenoidOn),
		.mainMotorOn(mainMotorOn), .feedMotorOn(feedMotorOn),
		.homeSwitch(homeSwitch), .paper_advance_switch(paperSw));
	printer_model u_prn (.mclk(mclk), .rstn(rstn),
		.mainMotorOn(mainMotorOn), .feedMotorOn(feedMotorOn),
		.glyphChar(glyphChar), .glyphCol(glyphCol),
		.homeSwitch(homeSwitch), .paper_advance_switch(paperSw),
		.colPattern(colPattern));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if ((|solenoidOn) === 1'b1 && !prevOn)
			q.push_back(solenoidOn);
		prevOn = |solenoidOn;
		if (cyc == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Waits up to 6000 cycles for room, then writes even if the data register is still full
	task automatic wr(input logic [7:0] b);
		for (int i = 0; i < 6000 && hostStatus[1] !== 1'b0; i++)
			@(posedge mclk);
		hostWrData <= b;
		hostWrStb <= 1'b1;
		@(posedge mclk);
		hostWrStb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic t_reset();
		`CHK("solenoids", 7'h00, solenoidOn)
		`CHK("motors", 2'b00, {mainMotorOn, feedMotorOn})
		$display("test reset done");
	endtask
	task automatic t_msg();
		hostMsgData <= 8'h5a;
		hostMsgStb <= 1'b1;
		@(posedge mclk);
		hostMsgStb <= 1'b0;
		@(posedge mclk);
		`CHK("msg byte", 8'h5a, hostRdData)
		`CHK("out full", 1'b1, hostStatus[0])
		hostRdStb <= 1'b1;
		@(posedge mclk);
		hostRdStb <= 1'b0;
		@(posedge mclk);
		`CHK("out full", 1'b0, hostStatus[0])
		$display("test msg done");
	endtask
	task automatic t_line(input int n, input logic term);
		logic [7:0] c;
		q.delete();
		for (int i = 0; i < n; i++)
			wr(8'h41 + 8'(i));
		if (term)
			wr(8'h0d);
		for (int i = 0; i < 9000 && feedMotorOn !== 1'b1; i++)
			@(posedge mclk);
		`CHK("feed motor on", 1'b1, feedMotorOn)
		`CHK("feed status", 1'b1, hostStatus[3])
		`CHK("print status", 1'b1, hostStatus[2])
		for (int i = 0; i < 2000 && feedMotorOn !== 1'b0; i++)
			@(posedge mclk);
		`CHK("feed motor", 1'b0, feedMotorOn)
		`CHK("pulses", 5 * n, q.size())
		for (int i = 0; i < q.size(); i++) begin
			c = 8'h41 + 8'(i / 5);
			`CHK("dots", {c[1:0], 5'h01 << (i % 5)}, q[i])
		end
		$display("test line %0d done", n);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_msg();
		t_line(2, 1'b1);
		t_line(40, 1'b0);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
